// File: rtl/sensor_mode_control_regs.sv
/*
 Serial slave with the ambient and proximity control registers, the ambient
 interrupt decision and proximity crosstalk subtraction.
 Assumes scl and sda arrive synchronous to core_clk and the wire is resolved outside.
*/
`timescale 1ns/10ps
`default_nettype none
module sensor_mode_control_regs
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   // Serial bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Measurement side
   input wire sensor_mode_control_pkg::ambient_sample_t ambient_sample,
   input wire sensor_mode_control_pkg::ambient_limits_t ambient_limits,
   input wire sensor_mode_control_pkg::proximity_sample_t proximity_raw,
   input wire logic [10:0] proximity_crosstalk_value,
   // Results and controls
   output logic ambient_irq,
   output sensor_mode_control_pkg::proximity_sample_t proximity_result,
   output sensor_mode_control_pkg::ambient_control_t ambient_control,
   output sensor_mode_control_pkg::proximity_control_t proximity_control,
   output logic chip_soft_reset
);
   import sensor_mode_control_pkg::*;

   state_t st_reg;
   state_t st_next;
   logic start_seen;
   logic stop_seen;
   logic scl_rise;
   logic scl_fall;
   logic wr_fire;
   logic addr_hit;
   logic out_of_range;

   function automatic logic [7:0] read_reg(input logic [7:0] ptr, input ambient_control_t a,
                                           input proximity_control_t p);
      logic [7:0] val;
      val = UNMAPPED_READ;
      if (ptr == AMBIENT_ADDR)
         val = a;
      else if (ptr == PROXIMITY_ADDR)
         val = p;
      return val;
   endfunction

   assign start_seen = st_reg.scl_q && scl_in && st_reg.sda_q && !sda_in;
   assign stop_seen = st_reg.scl_q && scl_in && !st_reg.sda_q && sda_in;
   assign scl_rise = !st_reg.scl_q && scl_in;
   assign scl_fall = st_reg.scl_q && !scl_in;
   assign wr_fire = (st_reg.phase == BUS_RX) && scl_fall && (st_reg.cnt == BYTE_BITS)
                    && st_reg.got_reg;
   assign addr_hit = (st_reg.phase == BUS_ADDR) && scl_fall && (st_reg.cnt == BYTE_BITS)
                     && (st_reg.shift[7:1] == SLAVE_ADDR);
   assign out_of_range = (ambient_sample.value > ambient_limits.upper)
                         || (ambient_sample.value < ambient_limits.lower);

   always_comb
   begin
      st_next = st_reg;
      st_next.scl_q = scl_in;
      st_next.sda_q = sda_in;
      st_next.soft_pulse = 1'b0;
      st_next.prox_res.valid = 1'b0;
      if (start_seen)
      begin
         st_next.phase = BUS_ADDR;
         st_next.cnt = 4'h0;
         st_next.sda_oe = 1'b0;
      end
      else if (stop_seen)
      begin
         st_next.phase = BUS_IDLE;
         st_next.sda_oe = 1'b0;
      end
      else
      begin
         unique case (st_reg.phase)
            BUS_IDLE:
            begin
               st_next.sda_oe = 1'b0;
            end
            BUS_ADDR, BUS_RX:
            begin
               if (scl_rise)
               begin
                  st_next.shift = {st_reg.shift[6:0], sda_in};
                  st_next.cnt = st_reg.cnt + 4'h1;
               end
               else if (scl_fall && st_reg.cnt == BYTE_BITS)
               begin
                  if (st_reg.phase == BUS_ADDR)
                  begin
                     st_next.phase = addr_hit ? BUS_ACK_ADDR : BUS_IDLE;
                     st_next.sda_oe = addr_hit;
                     st_next.rw = st_reg.shift[0];
                     st_next.got_reg = 1'b0;
                  end
                  else
                  begin
                     st_next.phase = BUS_ACK_RX;
                     st_next.sda_oe = 1'b1;
                     st_next.got_reg = 1'b1;
                     st_next.ptr = st_reg.got_reg ? st_reg.ptr + 8'h01 : st_reg.shift;
                  end
               end
            end
            BUS_ACK_ADDR:
            begin
               if (scl_fall)
               begin
                  st_next.cnt = 4'h0;
                  if (st_reg.rw)
                  begin
                     st_next.shift = read_reg(st_reg.ptr, st_reg.amb, st_reg.prox);
                     st_next.sda_oe = !st_next.shift[7];
                     st_next.phase = BUS_TX;
                  end
                  else
                  begin
                     st_next.sda_oe = 1'b0;
                     st_next.phase = BUS_RX;
                  end
               end
            end
            BUS_ACK_RX:
            begin
               if (scl_fall)
               begin
                  st_next.sda_oe = 1'b0;
                  st_next.cnt = 4'h0;
                  st_next.phase = BUS_RX;
               end
            end
            BUS_TX:
            begin
               if (scl_fall)
               begin
                  if (st_reg.cnt == LAST_TX_BIT)
                  begin
                     st_next.sda_oe = 1'b0;
                     st_next.phase = BUS_TX_ACK;
                     st_next.ptr = st_reg.ptr + 8'h01;
                  end
                  else
                  begin
                     st_next.shift = {st_reg.shift[6:0], 1'b0};
                     st_next.sda_oe = !st_reg.shift[6];
                     st_next.cnt = st_reg.cnt + 4'h1;
                  end
               end
            end
            BUS_TX_ACK:
            begin
               if (scl_rise)
                  st_next.nack = sda_in;
               else if (scl_fall)
               begin
                  st_next.cnt = 4'h0;
                  st_next.phase = st_reg.nack ? BUS_IDLE : BUS_TX;
                  st_next.shift = read_reg(st_reg.ptr, st_reg.amb, st_reg.prox);
                  st_next.sda_oe = !st_reg.nack && !st_next.shift[7];
               end
            end
            default:
            begin
               st_next.phase = BUS_IDLE;
               st_next.sda_oe = 1'b0;
            end
         endcase
      end
      if (!st_reg.amb.ambient_irq_enable)
         st_next.ambient_irq = 1'b0;
      else if (ambient_sample.valid)
         st_next.ambient_irq = out_of_range;
      if (proximity_raw.valid)
      begin
         st_next.prox_res.valid = 1'b1;
         if (!st_reg.prox.proximity_crosstalk_subtract_en)
            st_next.prox_res.value = proximity_raw.value;
         else if (proximity_raw.value > proximity_crosstalk_value)
            st_next.prox_res.value = proximity_raw.value - proximity_crosstalk_value;
         else
            st_next.prox_res.value = 11'h000;
      end
      if (wr_fire && st_reg.ptr == AMBIENT_ADDR)
      begin
         if (st_reg.shift[1])
         begin
            st_next.amb = ambient_control_t'(AMBIENT_RESET);
            st_next.prox = proximity_control_t'(PROXIMITY_RESET);
            st_next.ambient_irq = 1'b0;
            st_next.soft_pulse = 1'b1;
         end
         else
            st_next.amb = ambient_control_t'({2'h0, st_reg.shift[5:2], 1'b0, st_reg.shift[0]});
      end
      else if (wr_fire && st_reg.ptr == PROXIMITY_ADDR)
         // proximity fields, gain bits ignored and always stored as 0
         st_next.prox = proximity_control_t'({st_reg.shift[7], PROXIMITY_RSVD, st_reg.shift[4],
                                              2'h0, st_reg.shift[1:0]});
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
         st_reg <= STATE_INIT;
      else if (clk_en)
         st_reg <= st_next;
   end

   assign sda_out = st_reg.sda_out;
   assign sda_oe = st_reg.sda_oe;
   assign ambient_irq = st_reg.ambient_irq;
   assign proximity_result = st_reg.prox_res;
   assign ambient_control = st_reg.amb;
   assign proximity_control = st_reg.prox;
   assign chip_soft_reset = st_reg.soft_pulse;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   chk_amb_reset_val: assert property ($past(reset) |-> ambient_control == AMBIENT_RESET)
      else $error("ambient control not default after reset");
   chk_prox_reset_val: assert property ($past(reset)
      |-> proximity_control == PROXIMITY_RESET)
      else $error("proximity control not default after reset");
   chk_soft_reset_all: assert property (clk_en && wr_fire && st_reg.ptr == AMBIENT_ADDR
      && st_reg.shift[1] |=> chip_soft_reset && ambient_control == AMBIENT_RESET
      && proximity_control == PROXIMITY_RESET ##1 !chip_soft_reset)
      else $error("soft reset did not restore defaults");
   chk_bus_any_mode: assert property (clk_en && addr_hit && !start_seen && !stop_seen
      |=> sda_oe && st_reg.phase == BUS_ACK_ADDR)
      else $error("own address not acknowledged");
   chk_irq_gate_off: assert property (clk_en && !ambient_control.ambient_irq_enable
      |=> !ambient_irq)
      else $error("ambient interrupt raised while disabled");
   chk_irq_window: assert property (clk_en && ambient_sample.valid
      && ambient_control.ambient_irq_enable && !wr_fire |=> ambient_irq == $past(out_of_range))
      else $error("ambient window decision wrong");
   chk_distance_bit: assert property (clk_en && wr_fire && st_reg.ptr == PROXIMITY_ADDR
      |=> proximity_control.distance_report_enable == $past(st_reg.shift[7]))
      else $error("distance report enable not written");
   chk_xtalk_result: assert property (clk_en && proximity_raw.valid
      && proximity_control.proximity_crosstalk_subtract_en |=> proximity_result.valid
      && proximity_result.value <= $past(proximity_raw.value))
      else $error("crosstalk result exceeds raw value");
   chk_raw_pass: assert property (clk_en && proximity_raw.valid
      && !proximity_control.proximity_crosstalk_subtract_en
      |=> proximity_result.value == $past(proximity_raw.value))
      else $error("uncorrected proximity result altered");
   chk_prox_gain_rsvd: assert property (proximity_control.proximity_gain_sel == 2'h0
      && proximity_control.reserved == PROXIMITY_RSVD)
      else $error("proximity reserved gain code stored");

   cov_soft_reset: cover property (chip_soft_reset);
   cov_read_byte: cover property (st_reg.phase == BUS_TX ##1 st_reg.phase == BUS_TX_ACK);
   cov_irq_raise: cover property (!ambient_irq ##1 ambient_irq);
   cov_xtalk_floor: cover property (proximity_result.valid && proximity_result.value == 11'h000);
endmodule
`default_nettype wire

// File: rtl/sensor_mode_control_pkg.sv
/*
 Constants, field layouts and types for the sensor mode control registers.
 Assumes one core clock and serial bus pins already synchronous to it.
*/
// Summary of operation
// - The ambient control register is an 8-bit read/write register at 0x80 that resets to 0x00.
// - Writing 1 to ambient bit 1 restores every register to default and puts sensing in stand-by.
// - The serial slave accepts register accesses in every sensing mode.
// - With ambient bit 5 set an out-of-range ambient sample raises the interrupt, else none.
// - The proximity control register is an 8-bit read/write register at 0x81 that resets to 0x40.
// - Proximity bit 7 enables near/far status reporting, disabled by default.
// - With proximity bit 4 set the crosstalk value is subtracted from each proximity result.
// - The ambient decision compares 16-bit data with the upper and lower limits.
// - The slave answers at 7-bit address 0x23 with the read/write bit appended by the host.
package sensor_mode_control_pkg;
   localparam logic [7:0] AMBIENT_ADDR = 8'h80;
   localparam logic [7:0] PROXIMITY_ADDR = 8'h81;
   localparam logic [7:0] AMBIENT_RESET = 8'h00;
   localparam logic [7:0] PROXIMITY_RESET = 8'h40;
   localparam logic [6:0] SLAVE_ADDR = 7'h23;
   localparam logic [1:0] PROXIMITY_RSVD = 2'h2;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] LAST_TX_BIT = 4'h7;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   typedef struct packed {
      logic [1:0] reserved;
      logic ambient_irq_enable;
      logic [2:0] ambient_gain_sel;
      logic chip_soft_reset;
      logic ambient_run_select;
   } ambient_control_t;

   typedef struct packed {
      logic distance_report_enable;
      logic [1:0] reserved;
      logic proximity_crosstalk_subtract_en;
      logic [1:0] proximity_gain_sel;
      logic proximity_run_select;
      logic proximity_irq_enable;
   } proximity_control_t;

   typedef struct packed {
      logic valid;
      logic [15:0] value;
   } ambient_sample_t;

   typedef struct packed {
      logic valid;
      logic [10:0] value;
   } proximity_sample_t;

   typedef struct packed {
      logic [15:0] upper;
      logic [15:0] lower;
   } ambient_limits_t;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'h0,
      BUS_ADDR = 3'h1,
      BUS_ACK_ADDR = 3'h2,
      BUS_RX = 3'h3,
      BUS_ACK_RX = 3'h4,
      BUS_TX = 3'h5,
      BUS_TX_ACK = 3'h6
   } bus_phase_t;

   typedef struct packed {
      bus_phase_t phase;
      logic [3:0] cnt;
      logic [7:0] shift;
      logic [7:0] ptr;
      logic rw;
      logic got_reg;
      logic nack;
      logic scl_q;
      logic sda_q;
      logic sda_oe;
      logic sda_out;
      ambient_control_t amb;
      proximity_control_t prox;
      logic ambient_irq;
      proximity_sample_t prox_res;
      logic soft_pulse;
   } state_t;

   localparam state_t STATE_INIT = '{
      phase: BUS_IDLE, cnt: 4'h0, shift: 8'h00, ptr: 8'h00, rw: 1'b0, got_reg: 1'b0,
      nack: 1'b0, scl_q: 1'b1, sda_q: 1'b1, sda_oe: 1'b0, sda_out: 1'b0,
      amb: ambient_control_t'(AMBIENT_RESET), prox: proximity_control_t'(PROXIMITY_RESET),
      ambient_irq: 1'b0, prox_res: '{valid: 1'b0, value: 11'h000}, soft_pulse: 1'b0};
endpackage

// File: tb/i2c_host_model.sv
/*
 Serial bus host model with start, stop and byte tasks.
 Assumes a pulled-up data wire resolved in the bench from sda_low.
*/
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model
(
   // Clock
   input wire logic core_clk,
   // Bus wires
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Start or repeated start
   task automatic start();
      sda_low <= 1'b0;
      cyc(2);
      scl <= 1'b1;
      cyc(4);
      sda_low <= 1'b1;
      cyc(4);
      scl <= 1'b0;
      cyc(2);
   endtask
   task automatic stop();
      sda_low <= 1'b1;
      cyc(2);
      scl <= 1'b1;
      cyc(4);
      sda_low <= 1'b0;
      cyc(4);
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_low <= !b;
      cyc(2);
      scl <= 1'b1;
      cyc(2);
      r = sda;
      cyc(2);
      scl <= 1'b0;
      cyc(2);
   endtask
   // any byte, address with rw bit or data, MSB first
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic recv(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(!more, r);
   endtask
endmodule
`default_nettype wire

// File: tb/sensor_mode_control_regs_tb.sv
/*
 Bench for the control registers: bus accesses, interrupt and crosstalk.
 Assumes the host model above and a pulled-up open-drain data wire.
*/
`timescale 1ns/10ps
`default_nettype none
module sensor_mode_control_regs_tb;
   import sensor_mode_control_pkg::*;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic scl;
   logic sda_low;
   logic sda_oe;
   logic sda_drv;
   logic clk_en = 1'b1;
   wire logic sda;
   ambient_sample_t ambient_sample = '0;
   ambient_limits_t ambient_limits = '{16'h1000, 16'h0100};
   proximity_sample_t proximity_raw = '0;
   logic [10:0] proximity_crosstalk_value = 11'h000;
   logic ambient_irq;
   proximity_sample_t proximity_result;
   ambient_control_t ambient_control;
   proximity_control_t proximity_control;
   logic chip_soft_reset;
   int errors = 0;
   int samples_checked = 0;
   int pulses = 0;
   logic [7:0] d0;
   logic [7:0] d1;
   logic a;
   assign sda = !(sda_oe || sda_low);
   always #5 core_clk = !core_clk;
   always @(posedge core_clk) if (chip_soft_reset === 1'b1) pulses++;
   sensor_mode_control_regs i_dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_drv), .sda_oe(sda_oe),
      .ambient_sample(ambient_sample), .ambient_limits(ambient_limits),
      .proximity_raw(proximity_raw), .proximity_crosstalk_value(proximity_crosstalk_value),
      .ambient_irq(ambient_irq), .proximity_result(proximity_result),
      .ambient_control(ambient_control), .proximity_control(proximity_control),
      .chip_soft_reset(chip_soft_reset));
   i2c_host_model i_host (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic reg_write(input logic [7:0] p, input logic [7:0] d);
      logic a0;
      logic a1;
      logic a2;
      i_host.start();
      i_host.send(8'h46, a0);
      i_host.send(p, a1);
      i_host.send(d, a2);
      i_host.stop();
      check(a0 & a1 & a2, 1'b1);
   endtask
   task automatic reg_read(input logic [7:0] p, output logic [7:0] r0, output logic [7:0] r1);
      logic a0;
      logic a1;
      logic a2;
      i_host.start();
      i_host.send(8'h46, a0);
      i_host.send(p, a1);
      i_host.start();
      i_host.send(8'h47, a2);
      i_host.recv(1'b1, r0);
      i_host.recv(1'b0, r1);
      i_host.stop();
      check(a0 & a1 & a2, 1'b1);
   endtask
   task automatic amb(input logic [15:0] v, input logic exp);
      ambient_sample <= '{1'b1, v};
      @(posedge core_clk);
      ambient_sample.valid <= 1'b0;
      @(posedge core_clk);
      #1 check(ambient_irq, exp);
      @(posedge core_clk);
   endtask
   task automatic prx(input logic [10:0] raw, input logic [10:0] xt, input logic [10:0] exp);
      proximity_raw <= '{1'b1, raw};
      proximity_crosstalk_value <= xt;
      @(posedge core_clk);
      proximity_raw.valid <= 1'b0;
      #1 check(proximity_result, {1'b1, exp});
      @(posedge core_clk);
   endtask
   initial
   begin
      repeat (60000) @(posedge core_clk);
      errors++;
      end_sim();
   end
   initial
   begin
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      reg_read(8'h80, d0, d1);
      check({d0, d1}, 16'h0040);
      i_host.start();
      i_host.send(8'h48, a);
      i_host.stop();
      check(a, 1'b0);
      check(sda_drv, 1'b0);
      reg_write(8'h80, 8'hfd);
      reg_write(8'h81, 8'h9f);
      reg_read(8'h80, d0, d1);
      check({d0, d1}, 16'h3dd3);
      reg_read(8'h81, d0, d1);
      check({d0, d1}, 16'hd300);
      check({ambient_control, proximity_control}, 16'h3dd3);
      amb(16'h0800, 1'b0);
      amb(16'h1001, 1'b1);
      amb(16'h1000, 1'b0);
      amb(16'h00ff, 1'b1);
      clk_en <= 1'b0;
      amb(16'h0800, 1'b1);
      clk_en <= 1'b1;
      amb(16'h0100, 1'b0);
      prx(11'd100, 11'd30, 11'd70);
      prx(11'd20, 11'd30, 11'd0);
      amb(16'h2000, 1'b1);
      reg_write(8'h80, 8'h02);
      check({ambient_control, proximity_control}, 16'h0040);
      check(ambient_irq, 1'b0);
      check(pulses, 1);
      prx(11'd100, 11'd30, 11'd100);
      reg_write(8'h80, 8'h20);
      amb(16'h2000, 1'b1);
      reg_write(8'h80, 8'h00);
      check(ambient_irq, 1'b0);
      amb(16'h2000, 1'b0);
      end_sim();
   end
endmodule
`default_nettype wire
